/* hdl/scc_params.svh */
// Purpose: constants for the supply comparator control block
// Assumes: 8-bit byte address, 32-bit data words
// Notes:   offsets are byte addresses of aligned words
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

`define SCC_OFS_CTRL        8'h00
`define SCC_OFS_STATUS      8'h08
`define SCC_OFS_IRQ_MASK    8'h0C
`define SCC_OFS_IRQ_FLAG    8'h10
`define SCC_OFS_IRQ_SET     8'h14

`define SCC_POS_HALVE       30
`define SCC_POS_BIAS_HI     27
`define SCC_POS_BIAS_LO     24
`define SCC_POS_FALL        17
`define SCC_POS_RISE        16
`define SCC_POS_SETTLE_HI   10
`define SCC_POS_SETTLE_LO   8
`define SCC_POS_HYST        4
`define SCC_POS_IDLE        2
`define SCC_POS_EN          0

`define SCC_CTRL_USED_MASK  32'h4F03_0715

`define SCC_RST_HALVE       1'h1
`define SCC_RST_BIAS        4'h7
`define SCC_RST_SETTLE      3'h0

`define SCC_POS_ST_ACTIVE   0
`define SCC_POS_ST_OUT      1
`define SCC_POS_IRQ_EDGE    0
`define SCC_POS_IRQ_SETTLE  1

// shortest warm-up, in peripheral clock cycles; code n gives this << n
`define SCC_SETTLE_BASE     10'h004

`endif

/* hdl/scc_pkg.sv */
// Purpose: types and field helpers of the supply comparator control block
// Assumes: scc_params.svh on the include path
// Notes:   control word packing lives here so readback and checks agree
`include "scc_params.svh"

package scc_pkg;

  typedef struct packed {
    logic       halve_bias_current;
    logic [3:0] bias_level;
    logic       falling_edge_sense;
    logic       rising_edge_sense;
    logic [2:0] settle_time_select;
    logic       hysteresis_on;
    logic       idle_output_value;
    logic       enable;
  } scc_ctrl_t;

  typedef struct packed {
    logic above;
    logic beyond_hyst;
  } scc_analog_t;

  typedef enum logic [1:0] {
    SCC_OFF,
    SCC_WARMING,
    SCC_ACTIVE
  } scc_warm_state_t;

  function automatic logic [9:0] settle_cycles(input logic [2:0] code);
    return `SCC_SETTLE_BASE << code;
  endfunction

  function automatic scc_ctrl_t unpack_ctrl(input logic [31:0] w);
    scc_ctrl_t c;
    c.halve_bias_current = w[`SCC_POS_HALVE];
    c.bias_level         = w[`SCC_POS_BIAS_HI:`SCC_POS_BIAS_LO];
    c.falling_edge_sense = w[`SCC_POS_FALL];
    c.rising_edge_sense  = w[`SCC_POS_RISE];
    c.settle_time_select = w[`SCC_POS_SETTLE_HI:`SCC_POS_SETTLE_LO];
    c.hysteresis_on      = w[`SCC_POS_HYST];
    c.idle_output_value  = w[`SCC_POS_IDLE];
    c.enable             = w[`SCC_POS_EN];
    return c;
  endfunction

  function automatic logic [31:0] pack_ctrl(input scc_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`SCC_POS_HALVE]                        = c.halve_bias_current;
    w[`SCC_POS_BIAS_HI:`SCC_POS_BIAS_LO]     = c.bias_level;
    w[`SCC_POS_FALL]                         = c.falling_edge_sense;
    w[`SCC_POS_RISE]                         = c.rising_edge_sense;
    w[`SCC_POS_SETTLE_HI:`SCC_POS_SETTLE_LO] = c.settle_time_select;
    w[`SCC_POS_HYST]                         = c.hysteresis_on;
    w[`SCC_POS_IDLE]                         = c.idle_output_value;
    w[`SCC_POS_EN]                           = c.enable;
    return w;
  endfunction

endpackage

/* hdl/scc_sync.sv */
// Purpose: two-stage synchroniser for the analog comparator decisions
// Assumes: raw_in changes with no relation to clk_in
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps

module scc_sync (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire scc_pkg::scc_analog_t raw_in,
  output scc_pkg::scc_analog_t      sync_out
);

  scc_pkg::scc_analog_t stage1;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= raw_in;
      sync_out <= stage1;
    end
  end

endmodule

/* hdl/scc_settle_done_flag.sv */
// Purpose: warm-up sequencer: counts the selected settle time after enable
// Assumes: settle code held steady while enabled
// Notes:   dropping enable at any time returns to off with no done pulse
`timescale 1ns/1ps
`include "scc_params.svh"

module scc_settle_done_flag (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       enable_in,
  input  wire logic [2:0] settle_code_in,
  output logic            active_out,
  output logic            done_out
);

  scc_pkg::scc_warm_state_t state;
  scc_pkg::scc_warm_state_t next_state;
  logic [9:0]               count;
  logic [9:0]               next_count;
  wire  [9:0]               load_value = 10'(scc_pkg::settle_cycles(settle_code_in) - 10'h001);

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      scc_pkg::SCC_OFF: begin
        if (enable_in) begin
          next_state = scc_pkg::SCC_WARMING;
          next_count = load_value;
        end
      end
      scc_pkg::SCC_WARMING: begin
        if (!enable_in) begin
          next_state = scc_pkg::SCC_OFF;
        end else if (count == 10'h000) begin
          next_state = scc_pkg::SCC_ACTIVE;
        end else begin
          next_count = 10'(count - 10'h001);
        end
      end
      scc_pkg::SCC_ACTIVE: begin
        if (!enable_in) begin
          next_state = scc_pkg::SCC_OFF;
        end
      end
      default: next_state = scc_pkg::SCC_OFF;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state    <= scc_pkg::SCC_OFF;
      count    <= 10'h000;
      done_out <= 1'b0;
    end else begin
      state    <= next_state;
      count    <= next_count;
      done_out <= (state == scc_pkg::SCC_WARMING) && (next_state == scc_pkg::SCC_ACTIVE);
    end
  end

  assign active_out = (state == scc_pkg::SCC_ACTIVE);

  // cycles spent enabled but not yet active, only for the checks below
  logic [10:0] wait_cycles;
  always_ff @(posedge clk_in) begin
    if (!resetn_in || !enable_in) begin
      wait_cycles <= 11'h000;
    end else if (!active_out) begin
      wait_cycles <= 11'(wait_cycles + 11'h001);
    end
  end

  property p_settle_length;
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(active_out) |-> wait_cycles == 11'({1'b0, scc_pkg::settle_cycles(settle_code_in)} + 11'h001);
  endproperty
  a_settle_length: assert property (p_settle_length)
    else $error("warm-up length does not match settle code");

  property p_done_marks_start;
    @(posedge clk_in) disable iff (!resetn_in)
    done_out |-> active_out && !$past(active_out);
  endproperty
  a_done_marks_start: assert property (p_done_marks_start)
    else $error("done pulse not aligned with activation");

  property p_off_when_disabled;
    @(posedge clk_in) disable iff (!resetn_in)
    !enable_in |=> !active_out && !done_out;
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled)
    else $error("active while enable is clear");

endmodule

/* hdl/scc_top.sv */
// Purpose: control register bank and digital side of a supply comparator
// Assumes: 50 MHz clk_in, synchronous active-low reset, one-cycle strobes
// Notes:   analog decisions arrive asynchronously and are synchronised here
//
// Behaviour
// - bit 30 halves selected bias current; resets to one.
// - bits 27:24 select bias level and response time; reset 0x7.
// - bit 17 set: falling comparator output edge sets the edge flag.
// - bit 16 set: rising comparator output edge sets the edge flag.
// - bits 10:8 select warm-up of 4 to 512 clock cycles.
// - bit 2 is presented as comparator output while not active.
// - bit 0 turns the supply comparator on or off.
// - after enable, count warm-up, then raise active and done flag.
// - hysteresis on: output holds until difference exceeds 20 mV.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "scc_params.svh"

module scc_top (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic [7:0]           addr_in,
  input  wire logic [31:0]          wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [31:0]          rdata_out,
  input  wire scc_pkg::scc_analog_t analog_in,
  output logic                      analog_enable_out,
  output logic      [3:0]           bias_level_out,
  output logic                      halve_bias_current_out,
  output logic                      hysteresis_on_out,
  output logic                      comparator_out,
  output logic                      comparator_active_out,
  output logic                      irq_out
);

  scc_pkg::scc_ctrl_t   ctrl;
  scc_pkg::scc_analog_t analog_sync;
  logic [1:0]           irq_flags;
  logic [1:0]           irq_mask;
  logic                 decision;
  logic                 presented_q;
  logic                 warm_active;
  logic                 warm_done;

  // register decode
  wire wr_ctrl     = wr_in && (addr_in == `SCC_OFS_CTRL);
  wire wr_mask     = wr_in && (addr_in == `SCC_OFS_IRQ_MASK);
  wire wr_flag_clr = wr_in && (addr_in == `SCC_OFS_IRQ_FLAG);
  wire wr_flag_set = wr_in && (addr_in == `SCC_OFS_IRQ_SET);

  wire [31:0] ctrl_word   = scc_pkg::pack_ctrl(ctrl);
  wire [31:0] status_word = {30'h0000_0000, comparator_out, comparator_active_out};
  wire [31:0] mask_word   = {30'h0000_0000, irq_mask};
  wire [31:0] flag_word   = {30'h0000_0000, irq_flags};

  // unmapped and write-only addresses read as zero
  wire [31:0] read_mux =
    (addr_in == `SCC_OFS_CTRL)     ? ctrl_word   :
    (addr_in == `SCC_OFS_STATUS)   ? status_word :
    (addr_in == `SCC_OFS_IRQ_MASK) ? mask_word   :
    (addr_in == `SCC_OFS_IRQ_FLAG) ? flag_word   : 32'h0000_0000;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= rd_in ? read_mux : 32'h0000_0000;
    end
  end

  // control register; unused write bits are simply not stored
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl.halve_bias_current <= `SCC_RST_HALVE;
      ctrl.bias_level         <= `SCC_RST_BIAS;
      ctrl.falling_edge_sense <= 1'b0;
      ctrl.rising_edge_sense  <= 1'b0;
      ctrl.settle_time_select <= `SCC_RST_SETTLE;
      ctrl.hysteresis_on      <= 1'b0;
      ctrl.idle_output_value  <= 1'b0;
      ctrl.enable             <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl <= scc_pkg::unpack_ctrl(wdata_in);
    end
  end

  assign analog_enable_out      = ctrl.enable;
  assign bias_level_out         = ctrl.bias_level;
  assign halve_bias_current_out = ctrl.halve_bias_current;
  assign hysteresis_on_out      = ctrl.hysteresis_on;

  scc_sync u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .raw_in    (analog_in),
    .sync_out  (analog_sync)
  );

  scc_settle_done_flag u_settle_done_flag (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .enable_in      (ctrl.enable),
    .settle_code_in (ctrl.settle_time_select),
    .active_out     (warm_active),
    .done_out       (warm_done)
  );

  // with hysteresis the decision only moves once the front end reports
  // the difference beyond the band, which filters ripple near the trip point
  wire decision_moves = (analog_sync.above != decision) &&
                        (!ctrl.hysteresis_on || analog_sync.beyond_hyst);

  wire presented = warm_active ? decision : ctrl.idle_output_value;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      decision              <= 1'b0;
      comparator_out        <= 1'b0;
      presented_q           <= 1'b0;
      comparator_active_out <= 1'b0;
    end else begin
      if (decision_moves) begin
        decision <= analog_sync.above;
      end
      comparator_out        <= presented;
      presented_q           <= comparator_out;
      comparator_active_out <= warm_active;
    end
  end

  // edges are taken on the presented output, so a suitable idle value
  // avoids a spurious event when the comparator becomes active
  wire rise_seen  = comparator_out && !presented_q && ctrl.rising_edge_sense;
  wire fall_seen  = !comparator_out && presented_q && ctrl.falling_edge_sense;
  wire [1:0] hw_events = {warm_done, rise_seen || fall_seen};

  wire [1:0] flag_clear = wr_flag_clr ? wdata_in[1:0] : 2'b00;
  wire [1:0] flag_set   = wr_flag_set ? wdata_in[1:0] : 2'b00;
  // a set in the same cycle as a clear wins
  wire [1:0] next_irq_flags = (irq_flags & ~flag_clear) | flag_set | hw_events;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_flags <= 2'b00;
      irq_mask  <= 2'b00;
    end else begin
      irq_flags <= next_irq_flags;
      if (wr_mask) begin
        irq_mask <= wdata_in[1:0];
      end
    end
  end

  assign irq_out = |(irq_flags & irq_mask);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_halve_follows_write;
    wr_ctrl |=> halve_bias_current_out == $past(wdata_in[`SCC_POS_HALVE]);
  endproperty
  a_halve_follows_write: assert property (p_halve_follows_write)
    else $error("halve bias bit not taken from write");

  property p_bias_follows_write;
    wr_ctrl ##1 !wr_ctrl |-> bias_level_out == $past(wdata_in[`SCC_POS_BIAS_HI:`SCC_POS_BIAS_LO]);
  endproperty
  a_bias_follows_write: assert property (p_bias_follows_write)
    else $error("bias level not taken from write");

  property p_fall_sets_edge;
    fall_seen |=> irq_flags[`SCC_POS_IRQ_EDGE];
  endproperty
  a_fall_sets_edge: assert property (p_fall_sets_edge)
    else $error("falling edge lost");

  property p_rise_sets_edge;
    (comparator_out && !presented_q && ctrl.rising_edge_sense) |=> irq_flags[0];
  endproperty
  a_rise_sets_edge: assert property (p_rise_sets_edge)
    else $error("rising edge lost");

  property p_idle_value_shown;
    !warm_active |=> comparator_out == $past(ctrl.idle_output_value);
  endproperty
  a_idle_value_shown: assert property (p_idle_value_shown)
    else $error("inactive output differs from idle value");

  property p_enable_write;
    wr_ctrl |=> analog_enable_out == $past(wdata_in[`SCC_POS_EN]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bit not taken from write");

  property p_active_needs_enable;
    !analog_enable_out |-> ##2 !comparator_active_out || $past(analog_enable_out);
  endproperty
  a_active_needs_enable: assert property (p_active_needs_enable)
    else $error("active status without enable");

  property p_hyst_holds;
    ctrl.hysteresis_on && !analog_sync.beyond_hyst |=> $stable(decision);
  endproperty
  a_hyst_holds: assert property (p_hyst_holds)
    else $error("decision moved inside hysteresis band");

  property p_reserved_read_zero;
    rd_in && (addr_in == `SCC_OFS_CTRL) |=> (rdata_out & ~`SCC_CTRL_USED_MASK) == 32'h0;
  endproperty
  a_reserved_read_zero: assert property (p_reserved_read_zero)
    else $error("reserved control bits read nonzero");

  property p_readback;
    wr_ctrl ##1 rd_in && $past(addr_in) == `SCC_OFS_CTRL && addr_in == `SCC_OFS_CTRL
      |=> rdata_out == ($past(wdata_in, 2) & `SCC_CTRL_USED_MASK);
  endproperty
  a_readback: assert property (p_readback)
    else $error("control readback differs from last write");

  property p_flag_sticky;
    irq_flags[0] && !flag_clear[0] |=> irq_flags[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("edge flag dropped without clear");

  property p_rdata_idle_zero;
    !rd_in |=> rdata_out == 32'h0000_0000;
  endproperty
  a_rdata_idle_zero: assert property (p_rdata_idle_zero)
    else $error("read data not zero outside a read");

  property p_status_read;
    rd_in && (addr_in == `SCC_OFS_STATUS)
      |=> rdata_out == {30'h0000_0000, $past(comparator_out), $past(comparator_active_out)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read differs from output and active status");

  property p_masked_quiet;
    irq_mask == 2'b00 |-> !irq_out;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt raised with every source masked");

  property p_done_sets_flag;
    warm_done |=> irq_flags[`SCC_POS_IRQ_SETTLE];
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag)
    else $error("finished warm-up did not set its flag");

  property p_clear_settle;
    wr_flag_clr && wdata_in[`SCC_POS_IRQ_SETTLE] && !warm_done
      |=> !irq_flags[`SCC_POS_IRQ_SETTLE];
  endproperty
  a_clear_settle: assert property (p_clear_settle)
    else $error("warm-up flag survived its clear");

  property p_active_reported;
    warm_active |=> comparator_active_out;
  endproperty
  a_active_reported: assert property (p_active_reported)
    else $error("active status not reported");

  property p_active_shows_decision;
    warm_active |=> comparator_out == $past(decision);
  endproperty
  a_active_shows_decision: assert property (p_active_shows_decision)
    else $error("active output differs from the decision");

  property p_edge_needs_event;
    !irq_flags[`SCC_POS_IRQ_EDGE] && !flag_set[`SCC_POS_IRQ_EDGE] &&
      (comparator_out == presented_q) |=> !irq_flags[`SCC_POS_IRQ_EDGE];
  endproperty
  a_edge_needs_event: assert property (p_edge_needs_event)
    else $error("edge flag set with no output transition");

  property p_clear_edge;
    wr_flag_clr && wdata_in[`SCC_POS_IRQ_EDGE] && !rise_seen && !fall_seen
      |=> !irq_flags[`SCC_POS_IRQ_EDGE];
  endproperty
  a_clear_edge: assert property (p_clear_edge)
    else $error("edge flag survived its clear");

  property p_soft_set;
    wr_flag_set |=> (irq_flags & $past(wdata_in[1:0])) == $past(wdata_in[1:0]);
  endproperty
  a_soft_set: assert property (p_soft_set)
    else $error("software flag set not taken");

  property p_settle_write;
    wr_ctrl |=> ctrl.settle_time_select ==
      $past(wdata_in[`SCC_POS_SETTLE_HI:`SCC_POS_SETTLE_LO]);
  endproperty
  a_settle_write: assert property (p_settle_write)
    else $error("warm-up code not taken from write");

  property p_sense_write;
    wr_ctrl |=> ctrl.rising_edge_sense == $past(wdata_in[`SCC_POS_RISE]) &&
      ctrl.falling_edge_sense == $past(wdata_in[`SCC_POS_FALL]);
  endproperty
  a_sense_write: assert property (p_sense_write)
    else $error("edge sense bits not taken from write");

  property p_idle_write;
    wr_ctrl |=> ctrl.idle_output_value == $past(wdata_in[`SCC_POS_IDLE]);
  endproperty
  a_idle_write: assert property (p_idle_write)
    else $error("idle value not taken from write");

  property p_hyst_write;
    wr_ctrl |=> hysteresis_on_out == $past(wdata_in[`SCC_POS_HYST]);
  endproperty
  a_hyst_write: assert property (p_hyst_write)
    else $error("hysteresis bit not taken from write");

  property p_ctrl_holds;
    !wr_ctrl |=> $stable(ctrl_word);
  endproperty
  a_ctrl_holds: assert property (p_ctrl_holds)
    else $error("control word changed without a write");

endmodule

/* verification/tb_top.sv */
// Purpose: self-checking bench for the supply comparator control block
// Assumes: one-cycle strobes, read data the cycle after rd_in, analog drive is synchronous
// Notes:   config is only changed with the enable bit clear, so every enable goes via a
//          disabled write first
`timescale 1ns/1ps

module tb_top;
  logic                 clk_in;
  logic                 resetn_in;
  logic [7:0]           addr_in;
  logic [31:0]          wdata_in;
  logic                 wr_in;
  logic                 rd_in;
  logic [31:0]          rdata_out;
  scc_pkg::scc_analog_t analog_in;
  logic                 analog_enable_out;
  logic [3:0]           bias_level_out;
  logic                 halve_bias_current_out;
  logic                 hysteresis_on_out;
  logic                 comparator_out;
  logic                 comparator_active_out;
  logic                 irq_out;
  int                   n_mismatch;
  int                   cmp_count;
  logic [31:0]          d;
  int                   n;

  scc_top dut (
    .clk_in                 (clk_in),
    .resetn_in              (resetn_in),
    .addr_in                (addr_in),
    .wdata_in               (wdata_in),
    .wr_in                  (wr_in),
    .rd_in                  (rd_in),
    .rdata_out              (rdata_out),
    .analog_in              (analog_in),
    .analog_enable_out      (analog_enable_out),
    .bias_level_out         (bias_level_out),
    .halve_bias_current_out (halve_bias_current_out),
    .hysteresis_on_out      (hysteresis_on_out),
    .comparator_out         (comparator_out),
    .comparator_active_out  (comparator_active_out),
    .irq_out                (irq_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    addr_in  <= a;
    wdata_in <= w;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    r = rdata_out;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  task automatic drive(input logic above, input logic beyond);
    analog_in <= scc_pkg::scc_analog_t'({above, beyond});
    cyc(8);
  endtask

  // counts edges until active rises; bounded so a stuck sequencer cannot hang the run
  task automatic wait_act(output int k);
    k = 0;
    while (comparator_active_out !== 1'b1 && k < 600) begin
      cyc(1);
      k++;
    end
  endtask

  // enables with cfg; only the enable bit moves while the comparator is on
  task automatic enable(input logic [31:0] cfg);
    logic [31:0] cur;
    rd(8'h00, cur);
    wr(8'h00, cur & 32'hFFFF_FFFE);
    wr(8'h00, cfg);
    wr(8'h00, cfg | 32'h0000_0001);
  endtask

  task automatic wrap_up;
    $display("counts: compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    logic [31:0] cfg;
    n_mismatch = 0;
    cmp_count  = 0;
    resetn_in  = 1'b0;
    addr_in    = 8'h00;
    wdata_in   = 32'h0000_0000;
    wr_in      = 1'b0;
    rd_in      = 1'b0;
    analog_in  = scc_pkg::scc_analog_t'(2'h0);
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    cyc(1);

    rd(8'h00, d);
    chk(d, 32'h4700_0000);
    chk(32'(halve_bias_current_out), 32'h1);
    chk(32'(bias_level_out), 32'h7);
    chk(32'(analog_enable_out), 32'h0);
    wr(8'h00, 32'h4F03_0714);
    rd(8'h00, d);
    chk(d, 32'h4F03_0714);
    chk(32'(bias_level_out), 32'hF);
    chk(32'(hysteresis_on_out), 32'h1);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, d);
    chk(d, 32'h0000_0000);
    chk(32'(halve_bias_current_out), 32'h0);
    wr(8'h04, 32'hFFFF_FFFF);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h04, d);
    chk(d, 32'h0000_0000);
    rd(8'h00, d);
    chk(d, 32'h0000_0000);
    $display("test registers done");

    for (int c = 0; c < 8; c++) begin
      cfg = 32'h4700_0000 | (32'(c) << 8) | (32'(c & 1) << 2);
      wr(8'h10, 32'h0000_0003);
      wr(8'h00, cfg);
      cyc(3);
      chk(32'(comparator_out), 32'(c & 1));
      wr(8'h00, cfg | 32'h0000_0001);
      chk(32'(analog_enable_out), 32'h1);
      cyc(2);
      chk(32'(comparator_active_out), 32'h0);
      chk(32'(comparator_out), 32'(c & 1));
      wait_act(n);
      // one edge loads the counter and one registers the status output
      chk(32'(n + 2), (32'h4 << c) + 32'h2);
      rd(8'h10, d);
      chk(d, 32'h0000_0002);
      rd(8'h08, d);
      chk(d, 32'h0000_0001);
      wr(8'h00, cfg);
      cyc(3);
      chk(32'(comparator_active_out), 32'h0);
    end
    wr(8'h10, 32'h0000_0003);
    wr(8'h00, 32'h0000_0700);
    wr(8'h00, 32'h0000_0701);
    cyc(20);
    wr(8'h00, 32'h0000_0700);
    cyc(600);
    rd(8'h10, d);
    chk(d, 32'h0000_0000);
    chk(32'(comparator_active_out), 32'h0);
    $display("test warm-up done");

    for (int s = 0; s < 4; s++) begin
      enable(32'h4700_0000 | (32'(s) << 16));
      wait_act(n);
      wr(8'h10, 32'h0000_0003);
      drive(1'b1, 1'b1);
      chk(32'(comparator_out), 32'h1);
      rd(8'h10, d);
      chk(d, 32'(s & 1));
      wr(8'h10, 32'h0000_0001);
      drive(1'b0, 1'b1);
      chk(32'(comparator_out), 32'h0);
      rd(8'h10, d);
      chk(d, 32'((s >> 1) & 1));
    end
    $display("test edge sense done");

    enable(32'h4703_0010);
    wait_act(n);
    chk(32'(hysteresis_on_out), 32'h1);
    drive(1'b1, 1'b0);
    chk(32'(comparator_out), 32'h0);
    drive(1'b1, 1'b1);
    chk(32'(comparator_out), 32'h1);
    drive(1'b0, 1'b0);
    chk(32'(comparator_out), 32'h1);
    drive(1'b0, 1'b1);
    chk(32'(comparator_out), 32'h0);
    $display("test hysteresis done");

    wr(8'h00, 32'h4703_0010);
    wr(8'h10, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0000);
    wr(8'h14, 32'h0000_0001);
    chk(32'(irq_out), 32'h0);
    wr(8'h0C, 32'h0000_0001);
    chk(32'(irq_out), 32'h1);
    rd(8'h0C, d);
    chk(d, 32'h0000_0001);
    wr(8'h10, 32'h0000_0001);
    chk(32'(irq_out), 32'h0);
    wr(8'h0C, 32'h0000_0002);
    enable(32'h4700_0000);
    wait_act(n);
    cyc(1);
    chk(32'(irq_out), 32'h1);
    wr(8'h10, 32'h0000_0002);
    chk(32'(irq_out), 32'h0);
    $display("test interrupts done");
    wrap_up;
  end
endmodule
